// [rtl/pips_pkg.sv]
// constants, register map and types for the remappable pin fabric
// assumes a 32-bit classic wishbone bus and one 200 MHz core clock
package pips_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int unsigned NUM_IN     = 18;   // pin-selectable peripheral inputs
   localparam int unsigned PIN_MAX    = 22;   // largest remappable pin count
   localparam int unsigned SEL_W      = 5;    // selector field width
   localparam int unsigned NUM_FN     = 32;   // output function codes
   localparam int unsigned ADR_W      = 10;   // byte address window
   localparam int unsigned DAT_W      = 32;
   localparam int unsigned KEY_W      = 8;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [SEL_W-1:0] IN_SEL_RST  = 5'h1F;  // all inputs point at pin 31
   localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;  // null output function
   localparam logic             LOCK_RST    = 1'h0;   // unlocked out of reset

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [ADR_W-1:0] IN_SEL_BASE  = 10'h000;  // 18 words, one per input
   localparam logic [ADR_W-1:0] LOCK_OFS     = 10'h080;  // map_write_lock control
   localparam logic [ADR_W-1:0] KEY_OFS      = 10'h084;  // unlock_key_register
   localparam logic [ADR_W-1:0] STATUS_OFS   = 10'h088;  // lock and key state
   localparam logic [ADR_W-1:0] OUT_SEL_BASE = 10'h100;  // 22 words, one per pin

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned LOCK_BIT     = 0;
   localparam int unsigned STAT_LOCK    = 0;
   localparam int unsigned STAT_ONEWAY  = 1;
   localparam int unsigned STAT_ARMED   = 2;
   localparam int unsigned STAT_MISMAT  = 3;

   ////////////////////////////////////////////////////////////////////////////
   // unlock key bytes
   localparam logic [KEY_W-1:0] KEY_FIRST  = 8'h55;
   localparam logic [KEY_W-1:0] KEY_SECOND = 8'hAA;

   ////////////////////////////////////////////////////////////////////////////
   // input selector indices, in register order
   localparam int unsigned IDX_EXT_INT1    = 0;
   localparam int unsigned IDX_EXT_INT2    = 1;
   localparam int unsigned IDX_EXT_INT3    = 2;
   localparam int unsigned IDX_T0_CLOCK    = 3;
   localparam int unsigned IDX_T3_CLOCK    = 4;
   localparam int unsigned IDX_T5_CLOCK    = 5;
   localparam int unsigned IDX_CAPTURE1    = 6;
   localparam int unsigned IDX_CAPTURE2    = 7;
   localparam int unsigned IDX_CAPTURE3    = 8;
   localparam int unsigned IDX_T1_GATE     = 9;
   localparam int unsigned IDX_T3_GATE     = 10;
   localparam int unsigned IDX_T5_GATE     = 11;
   localparam int unsigned IDX_SER2_RX     = 12;
   localparam int unsigned IDX_SER2_CLK    = 13;
   localparam int unsigned IDX_SPI2_DIN    = 14;
   localparam int unsigned IDX_SPI2_CLK    = 15;
   localparam int unsigned IDX_SPI2_SS     = 16;
   localparam int unsigned IDX_PWM_FAULT   = 17;

   ////////////////////////////////////////////////////////////////////////////
   // unlock sequence states
   typedef enum logic [2:0] {
      KEY_IDLE  = 3'b001,
      KEY_HALF  = 3'b010,
      KEY_ARMED = 3'b100
   } pips_key_t;

endpackage

// [rtl/pips_remap_fabric.sv]
// remappable peripheral pin fabric: input selectors, output selectors,
// write lock with key sequence, shadow check, pin priority
// assumes a classic wishbone master and peripherals on the same clock;
// pin levels arrive asynchronously and are synchronised here
//
// Functional notes
// - one 5-bit pin field per peripheral input
// - field value n routes pin n
// - per-input selectors; pins may be shared
// - values past supported pins select nothing
// - at most 22 remappable pins, variant-sized
// - mapped output peripheral overrides default drive; input mapping only claims the pin
// - enabled analog beats any remapped peripheral
// - fixed peripherals keep default pin otherwise
// - separate input and output selector sets
// - interrupt and timer clock input selectors
// - serial2, spi2 and pwm fault selectors
// - i2c, serial1 and others never remapped
// - hardware guards against spurious map changes
// - inputs reset all ones, outputs zero
// - locked writes complete but change nothing
// - 55h, AAh, then one lock write
// - shadow mismatch raises configuration reset
`timescale 1ns/1ps

module pips_remap_fabric
   import pips_pkg::*;
#(
   parameter int unsigned PIN_COUNT = pips_pkg::PIN_MAX  // pins of this variant
) (
   // clock and reset
   input  wire logic                             CLK_SYS_I,
   input  wire logic                             RESETN_I,
   // wishbone slave
   input  wire logic                             WB_CYC_I,
   input  wire logic                             WB_STB_I,
   input  wire logic                             WB_WE_I,
   input  wire logic [pips_pkg::ADR_W-1:0]       WB_ADR_I,
   input  wire logic [3:0]                       WB_SEL_I,
   input  wire logic [pips_pkg::DAT_W-1:0]       WB_DAT_I,
   output logic      [pips_pkg::DAT_W-1:0]       WB_DAT_O,
   output logic                                  WB_ACK_O,
   // configuration
   input  wire logic                             ONE_WAY_LOCK_I,
   output logic                                  MISMATCH_RESET_O,
   // remappable pins
   input  wire logic [pips_pkg::PIN_MAX-1:0]     RP_PIN_I,
   input  wire logic [pips_pkg::PIN_MAX-1:0]     ANALOG_EN_I,
   output logic      [pips_pkg::PIN_MAX-1:0]     PIN_OUT_O,
   output logic      [pips_pkg::PIN_MAX-1:0]     PIN_OE_O,
   output logic      [pips_pkg::PIN_MAX-1:0]     PIN_CLAIMED_O,
   // fixed-pin digital functions sharing the pins
   input  wire logic [pips_pkg::PIN_MAX-1:0]     DEFAULT_OUT_I,
   input  wire logic [pips_pkg::PIN_MAX-1:0]     DEFAULT_OE_I,
   // peripheral side
   input  wire logic [pips_pkg::NUM_FN-1:0]      PERIPH_OUT_I,
   output logic      [pips_pkg::NUM_IN-1:0]      PERIPH_IN_O
);

   import pips_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // pick a bit of a 32-wide vector; pads hide codes past the 22 pins
   function automatic logic pick(input logic [NUM_FN-1:0] vec,
                                 input logic [SEL_W-1:0]  sel);
      pick = vec[sel];
   endfunction

   // selector names a pin that exists on this variant
   function automatic logic pin_exists(input logic [SEL_W-1:0] sel);
      pin_exists = (32'(sel) < PIN_COUNT);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   // only the listed inputs have selectors; other functions never route here
   logic [SEL_W-1:0]   in_sel_r    [NUM_IN];
   logic [SEL_W-1:0]   in_shadow_r [NUM_IN];
   logic [SEL_W-1:0]   out_sel_r   [PIN_MAX];
   logic [SEL_W-1:0]   out_shadow_r[PIN_MAX];
   logic               lock_r;
   logic               lock_shadow_r;
   pips_key_t          key_r;
   pips_key_t          key_nxt;
   logic               ack_r;
   logic [DAT_W-1:0]   rdat_r;
   logic [DAT_W-1:0]   rdat_nxt;
   logic               mismatch_r;
   logic               mismatch_nxt;
   logic [PIN_MAX-1:0] pin_meta_r;
   logic [PIN_MAX-1:0] pin_sync_r;
   logic [NUM_IN-1:0]  periph_in_r;
   logic [NUM_IN-1:0]  periph_in_nxt;
   logic [PIN_MAX-1:0] pin_out_r;
   logic [PIN_MAX-1:0] pin_out_nxt;
   logic [PIN_MAX-1:0] pin_oe_r;
   logic [PIN_MAX-1:0] pin_oe_nxt;
   logic [PIN_MAX-1:0] claimed_r;
   logic [PIN_MAX-1:0] claimed_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire               bus_req   = WB_CYC_I & WB_STB_I;
   wire               bus_wr    = bus_req & WB_WE_I & ack_r;   // acts at ack edge
   wire               lane0     = WB_SEL_I[0];
   wire [KEY_W-1:0]   wr_byte   = WB_DAT_I[KEY_W-1:0];
   wire [SEL_W-1:0]   wr_field  = WB_DAT_I[SEL_W-1:0];
   wire [ADR_W-1:0]   adr       = WB_ADR_I;
   wire [ADR_W-3:0]   word      = adr[ADR_W-1:2];
   wire [ADR_W-3:0]   in_word0  = IN_SEL_BASE[ADR_W-1:2];
   wire [ADR_W-3:0]   out_word0 = OUT_SEL_BASE[ADR_W-1:2];
   wire [ADR_W-3:0]   in_idx    = word - in_word0;
   wire [ADR_W-3:0]   out_idx   = word - out_word0;
   wire               hit_in    = (word >= in_word0) && (32'(in_idx) < NUM_IN);
   wire               hit_out   = (word >= out_word0) && (32'(out_idx) < PIN_MAX);
   wire               hit_lock  = (adr == LOCK_OFS);
   wire               hit_key   = (adr == KEY_OFS);
   wire               hit_stat  = (adr == STATUS_OFS);

   // map writes only while unlocked; a locked write still acks
   wire               map_wr_ok = bus_wr & lane0 & ~lock_r;
   wire               key_wr    = bus_wr & lane0 & hit_key;
   wire               lock_wr   = bus_wr & lane0 & hit_lock;

   // one-way option: once set, the lock cannot be cleared until reset
   wire               clear_barred = ONE_WAY_LOCK_I & lock_r;
   wire               lock_take    = lock_wr & (key_r == KEY_ARMED)
                                     & ~(clear_barred & ~WB_DAT_I[LOCK_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // unlock key sequencer; any other write breaks the sequence
   always_comb begin
      key_nxt = key_r;
      if (bus_wr) begin
         unique case (key_r)
            KEY_IDLE: begin
               key_nxt = (key_wr && wr_byte == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
            end
            KEY_HALF: begin
               key_nxt = (key_wr && wr_byte == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
            end
            KEY_ARMED: begin
               // only the very next write may move the lock
               key_nxt = KEY_IDLE;
            end
            default: begin
               key_nxt = KEY_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wishbone handshake: data registered, ack one cycle after request
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         ack_r  <= 1'h0;
         rdat_r <= 32'h0000_0000;
         key_r  <= KEY_IDLE;
      end else begin
         ack_r  <= bus_req & ~ack_r;
         rdat_r <= rdat_nxt;
         key_r  <= key_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   always_comb begin
      rdat_nxt = 32'h0000_0000;
      if (hit_in) begin
         rdat_nxt[SEL_W-1:0] = in_sel_r[in_idx[4:0]];
      end else if (hit_out) begin
         rdat_nxt[SEL_W-1:0] = out_sel_r[out_idx[4:0]];
      end else if (hit_lock) begin
         rdat_nxt[LOCK_BIT] = lock_r;
      end else if (hit_stat) begin
         rdat_nxt[STAT_LOCK]   = lock_r;
         rdat_nxt[STAT_ONEWAY] = ONE_WAY_LOCK_I;
         rdat_nxt[STAT_ARMED]  = (key_r == KEY_ARMED);
         rdat_nxt[STAT_MISMAT] = mismatch_r;
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = rdat_r;

   ////////////////////////////////////////////////////////////////////////////
   // lock bit and its shadow
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         lock_r        <= LOCK_RST;
         lock_shadow_r <= LOCK_RST;
      end else if (lock_take) begin
         lock_r        <= WB_DAT_I[LOCK_BIT];
         lock_shadow_r <= WB_DAT_I[LOCK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input selectors, one per destination input, with shadow copies
   // the shadow takes the same write so a disturbed cell shows as mismatch
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         for (int i = 0; i < NUM_IN; i++) begin
            in_sel_r[i]    <= IN_SEL_RST;
            in_shadow_r[i] <= IN_SEL_RST;
         end
      end else if (map_wr_ok && hit_in) begin
         in_sel_r[in_idx[4:0]]    <= wr_field;
         in_shadow_r[in_idx[4:0]] <= wr_field;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output selectors, one per pin, with shadow copies
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         for (int p = 0; p < PIN_MAX; p++) begin
            out_sel_r[p]    <= OUT_SEL_RST;
            out_shadow_r[p] <= OUT_SEL_RST;
         end
      end else if (map_wr_ok && hit_out) begin
         out_sel_r[out_idx[4:0]]    <= wr_field;
         out_shadow_r[out_idx[4:0]] <= wr_field;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // continuous shadow compare
   always_comb begin
      mismatch_nxt = (lock_r != lock_shadow_r);
      for (int i = 0; i < NUM_IN; i++) begin
         mismatch_nxt = mismatch_nxt | (in_sel_r[i] != in_shadow_r[i]);
      end
      for (int p = 0; p < PIN_MAX; p++) begin
         mismatch_nxt = mismatch_nxt | (out_sel_r[p] != out_shadow_r[p]);
      end
   end

   // held until the reset it requests clears the fabric
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         mismatch_r <= 1'h0;
      end else begin
         mismatch_r <= mismatch_r | mismatch_nxt;
      end
   end

   assign MISMATCH_RESET_O = mismatch_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser; only the second stage feeds routing
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         pin_meta_r <= 22'h000000;
         pin_sync_r <= 22'h000000;
      end else begin
         pin_meta_r <= RP_PIN_I;
         pin_sync_r <= pin_meta_r;
      end
   end

   // codes past the 22 pins read as absent
   wire [NUM_FN-1:0] pin_level = {10'h000, pin_sync_r};
   wire [NUM_FN-1:0] pin_analog = {10'h3FF, ANALOG_EN_I};

   ////////////////////////////////////////////////////////////////////////////
   // input routing: each input looks up its own pin, so sharing is free
   always_comb begin
      periph_in_nxt = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         // absent or analog pin gives a quiet low, never x
         if (pin_exists(in_sel_r[i]) && !pick(pin_analog, in_sel_r[i])) begin
            periph_in_nxt[i] = pick(pin_level, in_sel_r[i]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin ownership and output drive; analog first, then remap, then default
   always_comb begin
      pin_out_nxt = '0;
      pin_oe_nxt  = '0;
      claimed_nxt = '0;
      for (int p = 0; p < PIN_MAX; p++) begin
         if (p < PIN_COUNT && !ANALOG_EN_I[p]) begin
            for (int i = 0; i < NUM_IN; i++) begin
               claimed_nxt[p] = claimed_nxt[p] | (32'(in_sel_r[i]) == p);
            end
            if (out_sel_r[p] != OUT_SEL_RST) begin
               claimed_nxt[p] = 1'h1;
               pin_out_nxt[p] = pick(PERIPH_OUT_I, out_sel_r[p]);
               pin_oe_nxt[p]  = 1'h1;
            end else begin
               pin_out_nxt[p] = DEFAULT_OUT_I[p];
               pin_oe_nxt[p]  = DEFAULT_OE_I[p];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs; one cycle of routing latency for clean timing
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         periph_in_r <= 18'h00000;
         pin_out_r   <= 22'h000000;
         pin_oe_r    <= 22'h000000;
         claimed_r   <= 22'h000000;
      end else begin
         periph_in_r <= periph_in_nxt;
         pin_out_r   <= pin_out_nxt;
         pin_oe_r    <= pin_oe_nxt;
         claimed_r   <= claimed_nxt;
      end
   end

   assign PERIPH_IN_O   = periph_in_r;
   assign PIN_OUT_O     = pin_out_r;
   assign PIN_OE_O      = pin_oe_r;
   assign PIN_CLAIMED_O = claimed_r;

endmodule // pips_remap_fabric

// [verif/pips_fabric_monitor.sv]
// checker for the fabric bus handshake, read data and pin priority
// bound to pips_remap_fabric, sees only its ports, one clock domain
`timescale 1ns/1ps
module pips_fabric_monitor
   import pips_pkg::*;
#(
   parameter int unsigned PIN_COUNT = PIN_MAX
) (
   // clock, reset and bus
   input wire logic                  CLK_SYS_I,
   input wire logic                  RESETN_I,
   input wire logic                  WB_CYC_I,
   input wire logic                  WB_STB_I,
   input wire logic                  WB_WE_I,
   input wire logic [ADR_W-1:0]      WB_ADR_I,
   input wire logic [DAT_W-1:0]      WB_DAT_O,
   input wire logic                  WB_ACK_O,
   // pins and status
   input wire logic                  MISMATCH_RESET_O,
   input wire logic [PIN_MAX-1:0]    ANALOG_EN_I,
   input wire logic [PIN_MAX-1:0]    PIN_OE_O,
   input wire logic [PIN_MAX-1:0]    PIN_CLAIMED_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   //////////////////////////////////////////
   // request decode; input selector words end below 0x048
   wire logic req_w   = WB_CYC_I && WB_STB_I;
   wire logic sel_rd_w = req_w && !WB_WE_I && (WB_ADR_I < 10'h048);
   wire logic hole_rd_w = req_w && !WB_WE_I && (WB_ADR_I >= 10'h048) && (WB_ADR_I < 10'h080);
   //////////////////////////////////////////
   property p_ack_next; $rose(req_w) |=> WB_ACK_O; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
   property p_ack_cause; WB_ACK_O |-> $past(req_w); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_field_width; $rose(sel_rd_w) |=> WB_ACK_O && (WB_DAT_O[31:5] == 27'h0); endproperty
   a_field_width: assert property (p_field_width) else $error("selector wider than field");
   property p_hole_zero; $rose(hole_rd_w) |=> WB_ACK_O && (WB_DAT_O == 32'h0); endproperty
   a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
   property p_analog_oe; ($past(ANALOG_EN_I) & PIN_OE_O) == 22'h0; endproperty
   a_analog_oe: assert property (p_analog_oe) else $error("fabric drives analog pin");
   property p_analog_claim; ($past(ANALOG_EN_I) & PIN_CLAIMED_O) == 22'h0; endproperty
   a_analog_claim: assert property (p_analog_claim) else $error("analog pin claimed");
   property p_no_mismatch; !MISMATCH_RESET_O; endproperty
   a_no_mismatch: assert property (p_no_mismatch) else $error("shadow mismatch raised");
   // main scenarios reached
   c_read: cover property (WB_ACK_O && !WB_WE_I);
   c_write: cover property (WB_ACK_O && WB_WE_I);
   c_analog: cover property (ANALOG_EN_I != 22'h0);
endmodule // pips_fabric_monitor

bind pips_remap_fabric pips_fabric_monitor #(.PIN_COUNT(PIN_COUNT)) pips_fabric_monitor_inst (
   .CLK_SYS_I, .RESETN_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
   .MISMATCH_RESET_O, .ANALOG_EN_I, .PIN_OE_O, .PIN_CLAIMED_O);

// [verif/pips_far_model.sv]
// pads and peripherals beyond the fabric: pin levels, function outputs
// assumes the bench pulses shuffle_i; levels hold between pulses
`timescale 1ns/1ps
module pips_far_model
   import pips_pkg::*;
(
   // control
   input  wire logic                clk_i,
   input  wire logic                shuffle_i,
   // levels toward the fabric
   output logic      [PIN_MAX-1:0]  pin_o = '0,
   output logic      [NUM_FN-1:0]   fn_o = '0,
   output logic      [PIN_MAX-1:0]  dflt_out_o = '0,
   output logic      [PIN_MAX-1:0]  dflt_oe_o = '0
);
   // new random levels only on request, so expectations stay stable
   always @(posedge clk_i) begin
      if (shuffle_i) begin
         pin_o <= PIN_MAX'($urandom);
         fn_o <= $urandom;
         dflt_out_o <= PIN_MAX'($urandom);
         dflt_oe_o <= PIN_MAX'($urandom);
      end
   end
endmodule // pips_far_model

// [verif/pips_remap_fabric_test.sv]
// self-checking bench for the remap fabric: bus, routing, lock
// assumes the far model holds levels; a watcher checks queued notes
`timescale 1ns/1ps
module pips_remap_fabric_test;
   import pips_pkg::*;
   localparam int unsigned PC = 20;  // smaller variant, pins 20 and 21 absent
   typedef struct {int src; logic [31:0] exp; logic [31:0] msk;} pips_note_t;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, smp = 0, one_way = 0, shuf = 0;
   logic [9:0]  adr = 0;
   logic [31:0] dat = 0, rdat, fn, act;
   logic [21:0] ana = 0, pin, pout, poe, pclm, dout, doe;
   logic [17:0] pin_in;
   logic        ack, mis;
   logic [4:0]  sel [18];
   logic [4:0]  c;
   pips_note_t  q[$], nt;
   int n_mismatch = 0, compares = 0;
   always #2.5 clk = ~clk;
   pips_far_model pips_far_model_inst (.clk_i(clk), .shuffle_i(shuf), .pin_o(pin), .fn_o(fn),
      .dflt_out_o(dout), .dflt_oe_o(doe));
   pips_remap_fabric #(.PIN_COUNT(PC)) pips_remap_fabric_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
      .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .ONE_WAY_LOCK_I(one_way),
      .MISMATCH_RESET_O(mis), .RP_PIN_I(pin), .ANALOG_EN_I(ana), .PIN_OUT_O(pout),
      .PIN_OE_O(poe), .PIN_CLAIMED_O(pclm), .DEFAULT_OUT_I(dout), .DEFAULT_OE_I(doe),
      .PERIPH_OUT_I(fn), .PERIPH_IN_O(pin_in));
   //////////////////////////////////////////
   // watcher: oldest note against a read ack or a sample strobe
   always @(posedge clk) begin
      if (q.size() > 0 && ((ack === 1'b1 && we === 1'b0) || smp === 1'b1)) begin
         nt = q.pop_front();
         act = (nt.src == 0) ? rdat : (nt.src == 1) ? 32'(pin_in) : (nt.src == 2) ? 32'(pout)
            : (nt.src == 3) ? 32'(poe) : 32'(pclm);
         compares++;
         if ((act & nt.msk) !== (nt.exp & nt.msk)) begin
            n_mismatch++;
            $display("wrong value at %0t: source %0d got %h want %h", $time, nt.src, act, nt.exp);
         end
      end
   end
   //////////////////////////////////////////
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one classic cycle; the wait is bounded, slave latency not assumed
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      cyc <= 0;
      stb <= 0;
      we <= 0;
      if (k >= 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
      q.push_back('{0, e, m});
      wb(0, a, 32'h0);
   endtask
   // four edges cover the two sync flops and the output register
   task automatic chk(input int s, input logic [31:0] e, input logic [31:0] m);
      repeat (4) @(posedge clk);
      q.push_back('{s, e, m});
      smp <= 1;
      @(posedge clk);
      smp <= 0;
   endtask
   task automatic lock_seq(input logic v);
      wb(1, KEY_OFS, 32'(KEY_FIRST));
      wb(1, KEY_OFS, 32'(KEY_SECOND));
      wb(1, LOCK_OFS, 32'(v));
   endtask
   // expected peripheral inputs; absent or analog pins read 0
   function automatic logic [31:0] want_in(input logic [21:0] an);
      logic [31:0] r;
      r = 0;
      for (int i = 0; i < 18; i++) if (sel[i] < PC && !an[sel[i]]) r[i] = pin[sel[i]];
      return r;
   endfunction
   //////////////////////////////////////////
   initial begin
      void'($urandom(32'h32B3));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 18; i++) rd(10'(4 * i), 32'h1F, '1);
      rd(OUT_SEL_BASE, 32'h0, '1);
      chk(1, 32'h0, '1);
      $display("test reset values done");
      shuf <= 1;
      @(posedge clk);
      shuf <= 0;
      for (int i = 0; i < 18; i++) sel[i] = 5'($urandom_range(15, 0));
      sel[1] = sel[0];
      for (int i = 0; i < 18; i++) wb(1, 10'(4 * i), 32'(sel[i]));
      for (int i = 0; i < 18; i++) rd(10'(4 * i), 32'(sel[i]), '1);
      chk(1, want_in(ana), '1);
      sel[0] = 5'(PC);
      sel[3] = 5'h15;
      wb(1, 10'h000, 32'(sel[0]));
      wb(1, 10'h00C, 32'(sel[3]));
      chk(1, want_in(ana), '1);
      @(posedge clk);
      ana <= 22'h1 << sel[2];
      chk(1, want_in(22'h1 << sel[2]), '1);
      ana <= 22'h0;
      $display("test input routing done");
      c = 5'($urandom_range(31, 1));
      wb(1, OUT_SEL_BASE + 10'd64, 32'(c));
      chk(2, (32'(dout[17]) << 17) | (32'(fn[c]) << 16), 32'h30000);
      chk(3, (32'(doe[17]) << 17) | 32'h10000, 32'h30000);
      chk(4, 32'h10000, 32'h30000);
      $display("test output mapping done");
      lock_seq(1);
      rd(STATUS_OFS, 32'h1, 32'h1);
      wb(1, 10'h000, 32'h9);
      rd(10'h000, 32'(sel[0]), '1);
      wb(1, OUT_SEL_BASE + 10'd64, 32'h0);
      rd(OUT_SEL_BASE + 10'd64, 32'(c), '1);
      wb(1, LOCK_OFS, 32'h0);
      rd(STATUS_OFS, 32'h1, 32'h1);
      lock_seq(0);
      rd(STATUS_OFS, 32'h0, 32'h1);
      wb(1, KEY_OFS, 32'(KEY_FIRST));
      wb(1, 10'h000, 32'h7);
      wb(1, KEY_OFS, 32'(KEY_SECOND));
      wb(1, LOCK_OFS, 32'h1);
      rd(STATUS_OFS, 32'h0, 32'h1);
      rd(10'h000, 32'h7, '1);
      one_way <= 1;
      lock_seq(1);
      lock_seq(0);
      rd(STATUS_OFS, 32'h1, 32'h1);
      $display("test lock done");
      rd(10'h048, 32'h0, '1);
      wb(1, 10'h200, '1);
      rd(10'h200, 32'h0, '1);
      @(posedge clk);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      one_way <= 0;
      rd(STATUS_OFS, 32'h0, 32'h1);
      rd(10'h000, 32'h1F, '1);
      $display("test second reset done");
      complete_run();
   end
endmodule // pips_remap_fabric_test
